// ### uart_rx_map.svh
// Register map, field positions, reset values and divider counts for the dual receiver.
// Assumes a 12-bit byte address and 8-bit register data.
`ifndef UART_RX_MAP_SVH
`define UART_RX_MAP_SVH
`define A_T2CTL 12'h418
`define A_T2MODE 12'h419
`define A_T2RLO 12'h41A
`define A_T2RHI 12'h41B
`define A_SYSCFG 12'h440
`define A_UBASE 12'h420
`define A_USTEP 12'h008
`define A_IRQST 12'h430
`define A_IRQMSK 12'h431
`define O_CTRL 3'h0
`define O_DATA 3'h1
`define O_STAT 3'h2
`define O_SLAVE_ADDR 3'h3
`define O_SLAVE_MASK 3'h4
`define B_RXSEL 5
`define B_TXSEL 4
`define B_PS_HI 3
`define B_PS_LO 2
`define B_MPE 5
`define B_RXEN 4
`define B_RX9 2
`define B_TXF 1
`define B_RXF 0
`define B_FE 3
`define B_BR 2
`define B_OE 1
`define B_STEN 0
`define PS_DIV4 2'b00
`define PS_DIV16 2'b01
`define PS_DIV64 2'b10
`define PS_TC4 6'h03
`define PS_TC16 6'h0F
`define PS_TC64 6'h3F
`define TMR_MAX 16'hFFFF
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define OVS_MID 4'h7
`define OVS_LAST 4'hF
`define FDIV_LAST 4'hF
`define VEC_BASE 8'hA0
`define VEC_STEP 8'h04
`endif

// ### uart_rx_pkg.sv
// Types shared by the receiver core and the register block.
// Assumes the map header supplies every number.
package uart_rx_pkg;
    typedef enum logic [1:0] {MODE_SHIFT, MODE_8BIT, MODE_9FIX, MODE_9VAR} uart_mode_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rx_state_e;
    typedef struct packed {
        logic [7:0] data;
        logic ninth;
        logic stop_ok;
        logic brk;
    } rx_frame_s;
endpackage

// ### baud_timer.sv
// Timer used as a baud generator: prescaler and 16-bit up counter with reload.
// Assumes run is a level from the register block on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "uart_rx_map.svh"
module baud_timer (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [1:0] prescale,
    input wire logic [15:0] reload,
    output logic ovf
);
    import uart_rx_pkg::*;
    logic [5:0] pre_q;
    logic [15:0] cnt_q;
    // Code 11 is reserved; the timer then holds rather than guess a rate.
    wire ps_ok = (prescale != 2'b11);
    wire [5:0] tc = (prescale == `PS_DIV4) ? `PS_TC4 : (prescale == `PS_DIV16) ? `PS_TC16 : `PS_TC64; // RQ16
    wire step = run && ps_ok && (pre_q == tc); // RQ2
    wire wrap = (cnt_q == `TMR_MAX);

    // Prescaler and counter; an overflow reloads and gives one tick.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= 6'h00;
            cnt_q <= `RST_WORD;
            ovf <= 1'b0;
        end else begin
            pre_q <= (step || !run || !ps_ok) ? 6'h00 : pre_q + 6'h01; // RQ2
            if (step) begin
                cnt_q <= wrap ? reload : cnt_q + 16'h0001;
            end
            ovf <= step && wrap;
        end
    end
endmodule // baud_timer
`default_nettype wire

// ### uart_rx_core.sv
// One serial receiver: 16x oversampled frames for modes 1 to 3, bit-rate shift for mode 0.
// Assumes rxd is already synchronised and tick16 is a one-cycle pulse.
`timescale 1ns/100ps
`default_nettype none
`include "uart_rx_map.svh"
module uart_rx_core (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic rxd,
    input wire logic tick16,
    input wire logic enable,
    input wire logic shift_go,
    input wire uart_rx_pkg::uart_mode_e mode,
    output logic done,
    output var uart_rx_pkg::rx_frame_s frame
);
    import uart_rx_pkg::*;
    rx_state_e state_q;
    logic [3:0] ovs_q;
    logic [3:0] bit_q;
    logic [8:0] shreg_q;
    wire shift = (mode == MODE_SHIFT);
    wire nine = (mode == MODE_9FIX) || (mode == MODE_9VAR);
    wire bit_tick = shift || (ovs_q == `OVS_LAST);
    wire [3:0] last_bit = nine ? 4'h8 : 4'h7; // RQ6
    wire stop_ok = shift || rxd;
    wire [7:0] data = nine ? shreg_q[7:0] : shreg_q[8:1];
    wire ninth = nine ? shreg_q[8] : stop_ok; // RQ6

    // Frame sequencer; a start bit that is high at mid-bit is a glitch and is dropped.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= RX_IDLE;
            ovs_q <= 4'h0;
            bit_q <= 4'h0;
            shreg_q <= 9'h000;
            done <= 1'b0;
            frame <= '0;
        end else begin
            done <= 1'b0;
            if (tick16) begin
                ovs_q <= ovs_q + 4'h1;
                case (state_q)
                    RX_IDLE: begin
                        bit_q <= 4'h0;
                        if (enable && shift && shift_go) begin
                            state_q <= RX_BITS;
                        end else if (enable && !shift && !rxd) begin
                            state_q <= RX_START;
                            ovs_q <= 4'h0;
                        end
                    end
                    RX_START: begin
                        if (ovs_q == `OVS_MID) begin
                            state_q <= rxd ? RX_IDLE : RX_BITS;
                            ovs_q <= 4'h0;
                        end
                    end
                    RX_BITS: begin
                        if (bit_tick) begin
                            shreg_q <= {rxd, shreg_q[8:1]};
                            bit_q <= bit_q + 4'h1;
                            if (bit_q == last_bit) begin
                                state_q <= RX_STOP;
                            end
                        end
                    end
                    RX_STOP: begin
                        if (bit_tick) begin
                            frame.data <= data;
                            frame.ninth <= ninth;
                            frame.stop_ok <= stop_ok;
                            frame.brk <= !shift && (data == 8'h00) && !ninth; // RQ17
                            done <= 1'b1;
                            state_q <= RX_IDLE;
                        end
                    end
                    default: state_q <= RX_IDLE;
                endcase
            end
        end
    end
endmodule // uart_rx_core
`default_nettype wire

// ### uart_rx_status_multiproc_addr.sv
// Dual receiver register block: baud source selection, error status, interrupt flags,
// multiprocessor gating and hardware address recognition.
// Assumes a single-cycle register port and timer 1 overflow pulses on the same clock.
// Notes on behaviour
// (RQ1) Receive or transmit clock select set makes timer 2 that UART's baud clock.
// (RQ2) Timer 2 steps once every N oscillator cycles, N being 4, 16 or 64.
// (RQ3) Each UART picks its own source, so both may run at different rates.
// (RQ4) Missing stop bit sets the framing error flag until software clears it.
// (RQ5) Separate receive and transmit requests per UART, each with its own vector.
// (RQ6) Nine-bit modes take nine data bits, ninth into the status field, then stop.
// (RQ7) Nine-bit modes with multiprocessor enable interrupt only when ninth bit is one.
// (RQ8) Remote master sends addresses with ninth bit one, data with ninth bit zero.
// (RQ9) Multiprocessor enable has no effect on mode 0 shift reception.
// (RQ10) Mode 1 with multiprocessor enable interrupts only on a valid stop bit.
// (RQ11) Address recognition in modes 2 and 3 flags only given or broadcast matches.
// (RQ12) Only words whose ninth bit is one are treated as addresses.
// (RQ13) Given address is address AND mask; zero mask bits are don't-care.
// (RQ14) Broadcast address is address OR mask; its zero bits are don't-care.
// (RQ15) Address and mask reset to zero, so every address matches.
// (RQ16) Prescaler codes: 00 is /4, 01 is /16, 10 is /64, 11 reserved.
// (RQ17) All-zero data and ninth position sets the break detect flag.
// (RQ18) A byte completing over an unread one sets overrun; errors may interrupt.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "uart_rx_map.svh"
module uart_rx_status_multiproc_addr (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [11:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic [1:0] rxd_pin,
    input wire logic timer1_ovf,
    input wire logic [1:0] tx_done,
    output logic [1:0] tx_tick16,
    output logic irq,
    output logic [3:0] irq_req,
    output logic [7:0] irq_vector
);
    import uart_rx_pkg::*;

    logic [7:0] t2ctl_q;
    logic [7:0] t2mode_q;
    logic [7:0] syscfg_q;
    logic [15:0] t2rel_q;
    logic [3:0] irq_st_q;
    logic [3:0] irq_mask_q;
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [3:0] fdiv_q;
    logic [7:0] rdata_q;
    logic [7:0] vec_q;
    logic tmr2_ovf;
    logic [7:0] u_rdata [2];
    logic [1:0] u_hit;
    logic [1:0] rx_set;
    logic [1:0] rx_flag;
    logic [1:0] tx_flag;

    // Fixed rates: osc/2 is the 16x tick for mode 2, osc/16 the bit tick for mode 0.
    wire tick_osc2 = fdiv_q[0];
    wire tick_osc16 = (fdiv_q == `FDIV_LAST);

    // Global register decode.
    wire wr_t2ctl = wr_stb && (addr == `A_T2CTL);
    wire wr_t2mode = wr_stb && (addr == `A_T2MODE);
    wire wr_t2rlo = wr_stb && (addr == `A_T2RLO);
    wire wr_t2rhi = wr_stb && (addr == `A_T2RHI);
    wire wr_syscfg = wr_stb && (addr == `A_SYSCFG);
    wire wr_irqmsk = wr_stb && (addr == `A_IRQMSK);
    wire rd_irqst = rd_stb && (addr == `A_IRQST);
    wire [1:0] prescale = {syscfg_q[`B_PS_HI], syscfg_q[`B_PS_LO]};
    wire tmr2_run = t2ctl_q[`B_RXSEL] | t2ctl_q[`B_TXSEL] | t2mode_q[`B_RXSEL] | t2mode_q[`B_TXSEL];

    // Timer 2 in baud mode; it runs only while some direction has selected it.
    baud_timer u_timer2 (
        .clock(clock),
        .rst_n(rst_n),
        .run(tmr2_run),
        .prescale(prescale),
        .reload(t2rel_q),
        .ovf(tmr2_ovf)
    );

    // Receive pins cross into the clock domain through two flip-flops.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 2'b11;
            sync2_q <= 2'b11;
            fdiv_q <= 4'h0;
        end else begin
            sync1_q <= rxd_pin;
            sync2_q <= sync1_q;
            fdiv_q <= fdiv_q + 4'h1;
        end
    end

    // Timer and prescaler configuration registers.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            t2ctl_q <= `RST_BYTE;
            t2mode_q <= `RST_BYTE;
            syscfg_q <= `RST_BYTE;
            t2rel_q <= `RST_WORD;
        end else begin
            if (wr_t2ctl) t2ctl_q <= wdata;
            if (wr_t2mode) t2mode_q <= wdata;
            if (wr_syscfg) syscfg_q <= wdata;
            if (wr_t2rlo) t2rel_q[7:0] <= wdata;
            if (wr_t2rhi) t2rel_q[15:8] <= wdata;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_uart
            localparam logic [11:0] BASE = 12'(`A_UBASE + i * `A_USTEP);
            logic [7:4] ctrl_q;
            logic rx9_q;
            logic rxf_q;
            logic txf_q;
            logic sten_q;
            logic fe_q;
            logic br_q;
            logic oe_q;
            logic full_q;
            logic [7:0] data_q;
            logic [7:0] slave_address_q;
            logic [7:0] slave_address_mask_q;
            logic done;
            rx_frame_s frame;

            // Per-UART decode; UART 0 selects timer 2 in one register, UART 1 in the other.
            wire hit = (addr[11:3] == BASE[11:3]);
            wire [2:0] off = addr[2:0];
            wire wr_ctrl = wr_stb && hit && (off == `O_CTRL);
            wire wr_stat = wr_stb && hit && (off == `O_STAT);
            wire wr_slave_address = wr_stb && hit && (off == `O_SLAVE_ADDR);
            wire wr_slave_address_mask = wr_stb && hit && (off == `O_SLAVE_MASK);
            wire rd_data = rd_stb && hit && (off == `O_DATA);
            wire [7:0] sel_reg = (i == 0) ? t2ctl_q : t2mode_q;
            wire uart_mode_e mode = uart_mode_e'(ctrl_q[7:6]);
            wire mpe = ctrl_q[`B_MPE];
            // Modes 0 and 2 run from fixed rates, modes 1 and 3 from their selected timer.
            wire fixed_rate = (mode == MODE_SHIFT) || (mode == MODE_9FIX);
            wire fixed_tick = (mode == MODE_SHIFT) ? tick_osc16 : tick_osc2;
            wire rx_tick = fixed_rate ? fixed_tick : sel_reg[`B_RXSEL] ? tmr2_ovf : timer1_ovf; // RQ1 RQ3
            assign tx_tick16[i] = fixed_rate ? fixed_tick : sel_reg[`B_TXSEL] ? tmr2_ovf : timer1_ovf; // RQ1 RQ3

            uart_rx_core u_rx (
                .clock(clock),
                .rst_n(rst_n),
                .rxd(sync2_q[i]),
                .tick16(rx_tick),
                .enable(ctrl_q[`B_RXEN]),
                .shift_go(!rxf_q),
                .mode(mode),
                .done(done),
                .frame(frame)
            );

            // Address recognition against the given and the broadcast address.
            wire [7:0] given = slave_address_q & slave_address_mask_q; // RQ13
            wire [7:0] bcast = slave_address_q | slave_address_mask_q; // RQ14
            wire m_given = (((frame.data ^ given) & slave_address_mask_q) == 8'h00); // RQ13
            wire m_bcast = (((frame.data ^ bcast) & bcast) == 8'h00); // RQ14
            wire addr_ok = frame.ninth && (m_given || m_bcast); // RQ12 RQ8
            // Gating: mode 0 ignores the enable, mode 1 needs a good stop bit.
            wire gate_ok = (mode == MODE_SHIFT) ? 1'b1 // RQ9
                         : (mode == MODE_8BIT) ? frame.stop_ok // RQ10
                         : addr_ok; // RQ7 RQ11
            wire accept = done && (!mpe || gate_ok);
            wire ev_fe = done && (mode != MODE_SHIFT) && !frame.stop_ok; // RQ4
            wire ev_br = done && frame.brk; // RQ17
            wire ev_oe = accept && full_q; // RQ18
            assign rx_set[i] = accept || (sten_q && (ev_fe || ev_br || ev_oe)); // RQ18
            assign rx_flag[i] = rxf_q;
            assign tx_flag[i] = txf_q;
            assign u_hit[i] = hit;

            // Control bits written by software.
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl_q <= 4'h0;
                    sten_q <= 1'b0;
                end else begin
                    if (wr_ctrl) ctrl_q <= wdata[7:4];
                    if (wr_stat) sten_q <= wdata[`B_STEN];
                end
            end

            // Address and mask start at zero so that every frame with ninth bit one matches.
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    slave_address_q <= `RST_BYTE; // RQ15
                    slave_address_mask_q <= `RST_BYTE; // RQ15
                end else begin
                    if (wr_slave_address) slave_address_q <= wdata;
                    if (wr_slave_address_mask) slave_address_mask_q <= wdata;
                end
            end

            // Sticky flags; software clears by writing 0, and a same-cycle event wins.
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    rxf_q <= 1'b0;
                    txf_q <= 1'b0;
                    fe_q <= 1'b0;
                    br_q <= 1'b0;
                    oe_q <= 1'b0;
                end else begin
                    rxf_q <= rx_set[i] || (rxf_q && !(wr_ctrl && !wdata[`B_RXF]));
                    txf_q <= tx_done[i] || (txf_q && !(wr_ctrl && !wdata[`B_TXF]));
                    fe_q <= ev_fe || (fe_q && !(wr_stat && !wdata[`B_FE])); // RQ4
                    br_q <= ev_br || (br_q && !(wr_stat && !wdata[`B_BR])); // RQ17
                    oe_q <= ev_oe || (oe_q && !(wr_stat && !wdata[`B_OE])); // RQ18
                end
            end

            // Receive buffer; a new byte overwrites an unread one on the same edge that flags overrun.
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    data_q <= `RST_BYTE;
                    rx9_q <= 1'b0;
                    full_q <= 1'b0;
                end else begin
                    if (accept) data_q <= frame.data;
                    if (accept) rx9_q <= frame.ninth; // RQ6
                    full_q <= accept || (full_q && !rd_data);
                end
            end

            // Per-UART read selection; unused offsets read as zero.
            assign u_rdata[i] = (off == `O_CTRL) ? {ctrl_q, 1'b0, rx9_q, txf_q, rxf_q}
                              : (off == `O_DATA) ? data_q
                              : (off == `O_STAT) ? {4'h0, fe_q, br_q, oe_q, sten_q}
                              : (off == `O_SLAVE_ADDR) ? slave_address_q
                              : (off == `O_SLAVE_MASK) ? slave_address_mask_q
                              : 8'h00;
        end
    endgenerate

    // Request lines in vector order: UART 0 receive, UART 0 transmit, UART 1 receive, UART 1 transmit.
    wire [3:0] req = {tx_flag[1], rx_flag[1], tx_flag[0], rx_flag[0]}; // RQ5
    wire [3:0] events = {tx_done[1], rx_set[1], tx_done[0], rx_set[0]};

    // Highest arbitration rank wins the vector output.
    wire [7:0] vec_d = req[3] ? `VEC_BASE + 8'(3 * `VEC_STEP) // RQ5
                     : req[2] ? `VEC_BASE + 8'(2 * `VEC_STEP)
                     : req[1] ? `VEC_BASE + `VEC_STEP
                     : `VEC_BASE;

    // Read data mux for the whole map; unmapped addresses read as zero.
    wire [7:0] rd_glob = (addr == `A_T2CTL) ? t2ctl_q
                       : (addr == `A_T2MODE) ? t2mode_q
                       : (addr == `A_T2RLO) ? t2rel_q[7:0]
                       : (addr == `A_T2RHI) ? t2rel_q[15:8]
                       : (addr == `A_SYSCFG) ? syscfg_q
                       : (addr == `A_IRQST) ? {4'h0, irq_st_q}
                       : (addr == `A_IRQMSK) ? {4'h0, irq_mask_q}
                       : 8'h00;
    wire [7:0] rdata_d = u_hit[0] ? u_rdata[0] : u_hit[1] ? u_rdata[1] : rd_glob;

    // Interrupt status clears on read, but an event in the same cycle still lands.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_st_q <= 4'h0;
            irq_mask_q <= 4'h0;
        end else begin
            irq_st_q <= events | (irq_st_q & ~{4{rd_irqst}});
            if (wr_irqmsk) irq_mask_q <= wdata[3:0];
        end
    end

    // Read data stand for one cycle only, so a stale value never looks like an answer.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= `RST_BYTE;
            vec_q <= `VEC_BASE;
        end else begin
            rdata_q <= rd_stb ? rdata_d : 8'h00;
            vec_q <= vec_d;
        end
    end

    assign rdata = rdata_q;
    assign irq = |(irq_st_q & irq_mask_q);
    assign irq_req = req; // RQ5
    assign irq_vector = vec_q;
endmodule // uart_rx_status_multiproc_addr
`default_nettype wire

// ### uart_rx_monitor.sv
// Checker of the dual receiver register block, bound to its top ports.
// Assumes one clock domain and the register map header.
`timescale 1ns/100ps
`default_nettype none
`include "uart_rx_map.svh"
module uart_rx_monitor (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [11:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rdata,
    input wire logic [1:0] rxd_pin,
    input wire logic timer1_ovf,
    input wire logic [1:0] tx_done,
    input wire logic [1:0] tx_tick16,
    input wire logic irq,
    input wire logic [3:0] irq_req,
    input wire logic [7:0] irq_vector
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // A status read with no transmit event in the same cycle.
    sequence status_read_s;
        rd_stb && addr == `A_IRQST && tx_done == 2'b00;
    endsequence
    // The pending set held two edges, so the registered vector has caught up.
    sequence steady_s(logic [3:0] v);
        irq_req == v ##1 irq_req == v;
    endsequence
    rdata_idle_a: assert property (!rd_stb |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property (rd_stb && addr == 12'h7F0 |=> rdata == 8'h00)
        else $error("unmapped read returned data");
    tx0_flag_a: assert property (tx_done[0] |=> irq_req[1])
        else $error("transmit 0 flag not set");
    tx1_flag_a: assert property (tx_done[1] |=> irq_req[3])
        else $error("transmit 1 flag not set");
    flags_sticky_a: assert property (!wr_stb |=> (irq_req & $past(irq_req)) == $past(irq_req))
        else $error("flag dropped without a write");
    vec_idle_a: assert property (steady_s(4'h0) |-> irq_vector == `VEC_BASE)
        else $error("idle vector wrong");
    vec_top_a: assert property (irq_req[3] ##1 irq_req[3] |-> irq_vector == 8'hAC)
        else $error("top rank vector wrong");
    vec_tx0_a: assert property (steady_s(4'b0010) |-> irq_vector == 8'hA4)
        else $error("transmit 0 vector wrong");
    irq_clear_a: assert property (status_read_s |=> !irq || (irq_req & ~$past(irq_req)) != 4'h0)
        else $error("interrupt stayed high after status read");
endmodule // uart_rx_monitor
`default_nettype wire

// ### uart_node_model.sv
// Remote serial node that sends nine-bit frames onto the receive pins.
// Assumes the receiver runs mode 2: sixteen ticks of two clocks per bit.
`timescale 1ns/100ps
`default_nettype none
module uart_node_model (
    input wire logic clock,
    output logic [1:0] rxd
);
    localparam int BIT_CLKS = 32;
    initial rxd = 2'b11;
    // Start, eight data bits LSB first, ninth bit, stop, then one idle bit.
    // The caller marks addresses with a ninth bit of one and data with zero.
    task automatic send(input int u, input logic [7:0] d, input logic nine, input logic stop);
        logic [10:0] f;
        f = {stop, nine, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clock);
            rxd[u] <= f[i];
            repeat (BIT_CLKS - 1) @(posedge clock);
        end
        @(posedge clock);
        rxd[u] <= 1'b1;
        repeat (BIT_CLKS) @(posedge clock);
    endtask
endmodule // uart_node_model
`default_nettype wire

// ### uart_rx_status_multiproc_addr_test.sv
// Self-checking bench for the dual receiver register block.
// Assumes the node model and the monitor are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "uart_rx_map.svh"
module uart_rx_status_multiproc_addr_test;
    import uart_rx_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic rd_prev = 1'b0;
    logic timer1_ovf = 1'b0;
    logic [1:0] tx_done = 2'b00;
    logic [1:0] rxd_pin;
    logic [1:0] tx_tick16;
    logic [7:0] rdata;
    logic irq;
    logic [3:0] irq_req;
    logic [7:0] irq_vector;
    logic [7:0] exp_q[$];
    logic [7:0] msk_q[$];
    logic [7:0] e_v;
    logic [7:0] m_v;
    logic [7:0] d;
    // Each entry: data [9:2], ninth bit [1], flag expected [0].
    logic [9:0] words [4] = '{10'h30B, 10'h306, 10'h308, 10'h3FF};
    int failures = 0;
    int checked = 0;
    uart_rx_status_multiproc_addr u_uart_rx_status_multiproc_addr (.clock, .rst_n, .addr, .wdata,
        .wr_stb, .rd_stb, .rdata, .rxd_pin, .timer1_ovf, .tx_done, .tx_tick16, .irq, .irq_req, .irq_vector);
    uart_node_model u_uart_node_model (.clock, .rxd(rxd_pin));
    initial forever #50 clock = ~clock;
    // Random overflow pulses; mode 2 must ignore them.
    always @(posedge clock) timer1_ovf <= ($urandom_range(7) == 0);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask
    // The note goes in first; read data stand only in the cycle after the strobe.
    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
    endtask
    // Read data are compared mid-cycle, once they have settled.
    always @(posedge clock) rd_prev <= rd_stb;
    always @(negedge clock) begin
        if (rd_prev) begin
            e_v = exp_q.pop_front();
            m_v = msk_q.pop_front();
            check(rdata & m_v, e_v & m_v);
        end
    end
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        close_out;
    end
    initial begin
        void'($urandom(32'h9a1b_b1f9));
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        // Reset values, an unmapped place, clock select and prescaler codes.
        rd(12'h423, 8'h00, 8'hFF);
        rd(12'h424, 8'h00, 8'hFF);
        rd(12'h422, 8'h00, 8'hFF);
        rd(12'h7F0, 8'h00, 8'hFF);
        wr(`A_T2CTL, 8'h30);
        rd(`A_T2CTL, 8'h30, 8'h30);
        wr(`A_T2CTL, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(`A_SYSCFG, 8'(i << 2));
            rd(`A_SYSCFG, 8'(i << 2), 8'h0C);
        end
        // Plain nine-bit reception raises the unmasked interrupt; a status read drops it.
        wr(12'h431, 8'h01);
        wr(12'h420, 8'h90);
        d = 8'($urandom);
        u_uart_node_model.send(0, d, 1'b1, 1'b1);
        rd(12'h420, 8'h95, 8'hFF);
        rd(12'h421, d, 8'hFF);
        @(negedge clock);
        check({7'h00, irq}, 8'h01);
        rd(12'h430, 8'h01, 8'h0F);
        @(negedge clock);
        check({7'h00, irq}, 8'h00);
        // Mode 2 ticks the UART 0 transmit side at half the clock rate.
        d = {7'h00, tx_tick16[0]};
        @(negedge clock);
        check({7'h00, tx_tick16[0]}, d ^ 8'h01);
        // Two frames with no read between: the second overruns the first.
        wr(12'h420, 8'h90);
        u_uart_node_model.send(0, 8'h5A, 1'b0, 1'b1);
        u_uart_node_model.send(0, 8'hA5, 1'b0, 1'b1);
        rd(12'h422, 8'h02, 8'h0E);
        rd(12'h421, 8'hA5, 8'hFF);
        // A missing stop bit, then an all-zero frame that is also a break.
        for (int i = 0; i < 2; i++) begin
            wr(12'h420, 8'h90);
            wr(12'h422, 8'h00);
            u_uart_node_model.send(0, i ? 8'h00 : 8'h3C, 1'b0, 1'b0);
            rd(12'h422, i ? 8'h0C : 8'h08, 8'h0E);
            rd(12'h421, i ? 8'h00 : 8'h3C, 8'hFF);
        end
        // Address 1100_0000 with mask 1111_1101: given, miss, data word, broadcast.
        wr(12'h422, 8'h00);
        wr(12'h423, 8'hC0);
        wr(12'h424, 8'hFD);
        for (int i = 0; i < 4; i++) begin
            wr(12'h420, 8'hB0);
            u_uart_node_model.send(0, words[i][9:2], words[i][1], 1'b1);
            rd(12'h420, {7'h00, words[i][0]}, 8'h01);
            rd(12'h421, (i == 3) ? 8'hFF : 8'hC2, 8'hFF);
        end
        // Transmit completions are masked from the line but ranked on the vector.
        wr(12'h420, 8'hB0);
        rd(12'h430, 8'h01, 8'h0F);
        @(posedge clock);
        tx_done <= 2'b10;
        @(posedge clock);
        tx_done <= 2'b01;
        @(posedge clock);
        tx_done <= 2'b00;
        repeat (2) @(negedge clock);
        check({4'h0, irq_req}, 8'h0A);
        check(irq_vector, 8'hAC);
        check({7'h00, irq}, 8'h00);
        wr(12'h428, 8'h00);
        repeat (2) @(negedge clock);
        check(irq_vector, 8'hA4);
        rd(12'h430, 8'h0A, 8'h0F);
        repeat (4) @(posedge clock);
        close_out;
    end
endmodule // uart_rx_status_multiproc_addr_test
bind uart_rx_status_multiproc_addr uart_rx_monitor u_uart_rx_monitor (.clock, .rst_n, .addr, .wdata,
    .wr_stb, .rd_stb, .rdata, .rxd_pin, .timer1_ovf, .tx_done, .tx_tick16, .irq, .irq_req, .irq_vector);
`default_nettype wire
